//--- dmps_consts.svh
`ifndef DMPS_CONSTS_SVH
`define DMPS_CONSTS_SVH

`define DMPS_CLK_MHZ        100
`define DMPS_MCLK_TO_NS     1000
`define DMPS_MCLK_TO_CYC    ((`DMPS_MCLK_TO_NS * `DMPS_CLK_MHZ + 999) / 1000)
`define DMPS_BCLK_TO_NS     10000
`define DMPS_BCLK_TO_CYC    ((`DMPS_BCLK_TO_NS * `DMPS_CLK_MHZ + 999) / 1000)
`define DMPS_RAMP_SAMPLES   800
`define DMPS_RATIO_TOL      11'h020
`define DMPS_NARROW_LIMIT   11'h0e0
`define DMPS_GROUP_DELAY    4'ha
`define DMPS_WIDE_PASS      10'h1c6
`define DMPS_WIDE_STOP      10'h222
`define DMPS_NARROW_PASS    10'h0f7
`define DMPS_NARROW_STOP    10'h2f1
`define DMPS_RATIO_WIDE     11'h100
`define DMPS_RATIO_NARROW   11'h080
`define DMPS_RATE_HOLD      11'h402
`define DMPS_QUIET_FRAMES   11'h328

`endif

//--- dmps_pkg.sv
package dmps_pkg;
   typedef enum logic [1:0] {
      DMPS_OFF     = 2'h0,
      DMPS_STANDBY = 2'h1,
      DMPS_ENABLED = 2'h3,
      DMPS_MUTING  = 2'h2
   } dmps_pwr_t;

   typedef logic [10:0] dmps_ratio_t;
   typedef logic [9:0]  dmps_gain_t;
   typedef logic [9:0]  dmps_edge_t;
endpackage

//--- dmps_if.sv
`timescale 1ns/1ps
interface dmps_if;
   logic mclk;
   logic bclk;
   logic lrclk;
   logic mute_n;

   modport device (input mclk, input bclk, input lrclk, input mute_n);
   modport host (output mclk, output bclk, output lrclk, output mute_n);
endinterface

//--- dmps_host.sv
`timescale 1ns/1ps
`include "dmps_consts.svh"
module dmps_host #(
   parameter int MCLK_HALF = 4
) (
   input  wire logic          core_clk_i,
   input  wire logic          reset_n_i,
   input  wire logic          clk_en_i,
   input  wire logic          mclk_run_i,
   input  wire logic          bclk_run_i,
   input  wire logic          mute_req_i,
   input  wire logic          ratio_sel_i,
   dmps_if.host               pins,
   output logic               mclk_on_o,
   output logic               hold_o
);
   import dmps_pkg::*;

   typedef struct packed {
      logic        mclk_on;
      logic        stopping;
      logic        hold;
      logic [7:0]  div;
      logic        mclk;
      logic        bclk;
      logic        lrclk;
      logic        mute_n;
      logic        ratio_sel;
      dmps_ratio_t frame_cnt;
      dmps_ratio_t hold_cnt;
      dmps_ratio_t quiet_cnt;
   } dmps_host_st_t;

   dmps_host_st_t q;
   dmps_host_st_t d;
   dmps_ratio_t   ratio;
   logic          mclk_rise;
   logic          frame_tick;

   generate
      if (MCLK_HALF < 1 || MCLK_HALF > 255) begin : g_bad
         $error("MCLK_HALF out of range");
      end
   endgenerate

   always_comb begin
      d = q;
      ratio = q.ratio_sel ? `DMPS_RATIO_NARROW : `DMPS_RATIO_WIDE;
      mclk_rise = 1'b0;
      frame_tick = 1'b0;
      if (q.mclk_on) begin
         if (q.div == 8'(MCLK_HALF - 1)) begin
            d.div = 8'h00;
            d.mclk = ~q.mclk;
            mclk_rise = ~q.mclk;
         end else begin
            d.div = q.div + 8'h01;
         end
      end else begin
         d.div = 8'h00;
         d.mclk = 1'b0;
      end
      if (mclk_rise) begin
         if (q.frame_cnt == ratio - 11'h001) begin
            d.frame_cnt = 11'h000;
            d.lrclk = 1'b0;
            frame_tick = 1'b1;
         end else begin
            d.frame_cnt = q.frame_cnt + 11'h001;
            if (q.frame_cnt == (ratio >> 1) - 11'h001) begin
               d.lrclk = 1'b1;
            end
         end
      end
      // Bit clock follows mclk so its period never beats mclk
      d.bclk = d.mclk & bclk_run_i;
      // Ratio change: hold mute for the whole settling span
      if (q.mclk_on && ratio_sel_i != q.ratio_sel) begin
         d.ratio_sel = ratio_sel_i;
         d.frame_cnt = 11'h000;
         d.hold_cnt = `DMPS_RATE_HOLD;
      end else if (frame_tick && q.hold_cnt != 11'h000) begin
         d.hold_cnt = q.hold_cnt - 11'h001;
      end
      if (!q.mclk_on) begin
         d.ratio_sel = ratio_sel_i;
         d.stopping = 1'b0;
         if (mclk_run_i) begin
            d.mclk_on = 1'b1;
         end
      end else if (!mclk_run_i && !q.stopping) begin
         // Quiet shutdown: mute first, clock stays while ramping
         d.stopping = 1'b1;
         d.quiet_cnt = `DMPS_QUIET_FRAMES;
      end else if (q.stopping) begin
         if (mclk_run_i) begin
            d.stopping = 1'b0;
         end else if (q.quiet_cnt == 11'h000) begin
            d.mclk_on = 1'b0;
         end else if (frame_tick) begin
            d.quiet_cnt = q.quiet_cnt - 11'h001;
         end
      end
      d.mute_n = d.mclk_on & ~mute_req_i & ~d.stopping & (d.hold_cnt == 11'h000);
      // Registered so the output comes straight from a flop
      d.hold   = d.stopping | (d.hold_cnt != 11'h000);
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else if (clk_en_i) begin
         q <= d;
      end
   end

   assign pins.mclk   = q.mclk;
   assign pins.bclk   = q.bclk;
   assign pins.lrclk  = q.lrclk;
   assign pins.mute_n = q.mute_n;
   assign mclk_on_o   = q.mclk_on;
   assign hold_o      = q.hold;
endmodule // dmps_host

//--- dmps_device.sv
`timescale 1ns/1ps
`include "dmps_consts.svh"
module dmps_device #(
   parameter int RAMP_LEN = `DMPS_RAMP_SAMPLES
) (
   input  wire logic          core_clk_i,
   input  wire logic          reset_n_i,
   input  wire logic          clk_en_i,
   dmps_if.device             pins,
   output dmps_pkg::dmps_pwr_t   state_o,
   output logic               charge_pump_on_o,
   output logic               out_path_on_o,
   output dmps_pkg::dmps_gain_t  gain_o,
   output dmps_pkg::dmps_ratio_t ratio_o,
   output logic               ratio_lock_o,
   output logic               narrow_mode_o,
   output dmps_pkg::dmps_edge_t  pass_edge_o,
   output dmps_pkg::dmps_edge_t  stop_edge_o,
   output logic               filter_ready_o
);
   import dmps_pkg::*;

   localparam logic [7:0]  MCLK_TO = 8'(`DMPS_MCLK_TO_CYC);
   localparam logic [11:0] BCLK_TO = 12'(`DMPS_BCLK_TO_CYC);
   localparam dmps_gain_t  FULL    = 10'(RAMP_LEN);

   typedef struct packed {
      dmps_pwr_t   st;
      logic [2:0]  mclk_s;
      logic [2:0]  bclk_s;
      logic [2:0]  lrclk_s;
      logic [1:0]  mute_s;
      logic [7:0]  mclk_to;
      logic [11:0] bclk_to;
      logic        mclk_act;
      logic        bclk_act;
      dmps_ratio_t edge_cnt;
      dmps_ratio_t ratio;
      logic        lock;
      logic        narrow;
      dmps_edge_t  pass_edge;
      dmps_edge_t  stop_edge;
      dmps_gain_t  gain;
      logic [3:0]  lat_cnt;
      logic        ready;
      logic        pump;
      logic        path;
   } dmps_dev_st_t;

   dmps_dev_st_t q;
   dmps_dev_st_t d;
   logic         mclk_edge;
   logic         mclk_rise;
   logic         bclk_edge;
   logic         frame;
   logic         play;
   dmps_ratio_t  diff;

   generate
      if (RAMP_LEN < 1 || RAMP_LEN > 1023) begin : g_bad
         $error("RAMP_LEN out of range");
      end
   endgenerate

   always_comb begin
      d = q;
      // Bit 0 of each chain feeds only bit 1; bit 2 of the three clock chains is the edge history, mute has no bit 2
      d.mclk_s  = {q.mclk_s[1:0], pins.mclk};
      d.bclk_s  = {q.bclk_s[1:0], pins.bclk};
      d.lrclk_s = {q.lrclk_s[1:0], pins.lrclk};
      d.mute_s  = {q.mute_s[0], pins.mute_n};
      mclk_edge = q.mclk_s[1] ^ q.mclk_s[2];
      mclk_rise = q.mclk_s[1] & ~q.mclk_s[2];
      bclk_edge = q.bclk_s[1] ^ q.bclk_s[2];
      frame     = q.lrclk_s[1] & ~q.lrclk_s[2] & q.bclk_act;
      // One decoded level serves both channels
      play      = q.mute_s[1];

      // Timeouts run on the core clock, so a dead mclk is still seen
      if (mclk_edge) begin
         d.mclk_to  = 8'h00;
         d.mclk_act = 1'b1;
      end else if (q.mclk_to == MCLK_TO - 8'h01) begin
         d.mclk_act = 1'b0;
      end else begin
         d.mclk_to = q.mclk_to + 8'h01;
      end
      if (bclk_edge) begin
         d.bclk_to  = 12'h000;
         d.bclk_act = 1'b1;
      end else if (q.bclk_to == BCLK_TO - 12'h001) begin
         d.bclk_act = 1'b0;
      end else begin
         d.bclk_to = q.bclk_to + 12'h001;
      end

      // Ratio: mclk rises per frame, stable twice within tolerance
      if (mclk_rise && q.edge_cnt != 11'h7ff) begin
         d.edge_cnt = q.edge_cnt + 11'h001;
      end
      diff = (q.edge_cnt > q.ratio) ? q.edge_cnt - q.ratio : q.ratio - q.edge_cnt;
      if (frame) begin
         d.edge_cnt  = {10'h000, mclk_rise};
         d.ratio     = q.edge_cnt;
         d.lock      = (diff <= `DMPS_RATIO_TOL);
         d.narrow    = (q.edge_cnt < `DMPS_NARROW_LIMIT);
         d.pass_edge = d.narrow ? `DMPS_NARROW_PASS : `DMPS_WIDE_PASS;
         d.stop_edge = d.narrow ? `DMPS_NARROW_STOP : `DMPS_WIDE_STOP;
      end

      // Power sequencer
      unique case (q.st)
         DMPS_OFF: begin
            d.gain = 10'h000;
            if (q.mclk_act && q.bclk_act) begin
               d.st = play ? DMPS_ENABLED : DMPS_STANDBY;
            end
         end
         DMPS_STANDBY: begin
            d.gain = 10'h000;
            // Bit clock loss alone keeps standby
            if (play && q.bclk_act) begin
               d.st = DMPS_ENABLED;
            end
         end
         DMPS_ENABLED: begin
            d.gain = FULL;
            if (!play || !q.bclk_act) begin
               d.st = DMPS_MUTING;
            end
         end
         DMPS_MUTING: begin
            if (!q.bclk_act) begin
               // No frames left to ramp against
               d.gain = 10'h000;
               d.st   = DMPS_STANDBY;
            end else if (play) begin
               d.gain = FULL;
               d.st   = DMPS_ENABLED;
            end else if (q.gain == 10'h000) begin
               d.st = DMPS_STANDBY;
            end else if (frame) begin
               d.gain = q.gain - 10'h001;
            end
         end
      endcase
      // Any entry to enabled lands at full scale at once, no ramp up
      if (d.st == DMPS_ENABLED) begin
         d.gain = FULL;
      end
      if (!q.mclk_act) begin
         d.st   = DMPS_OFF;
         d.gain = 10'h000;
      end

      // Filter settles a fixed number of samples after enable
      if (d.st != DMPS_ENABLED) begin
         d.lat_cnt = 4'h0;
         d.ready   = 1'b0;
      end else if (frame && q.lat_cnt != `DMPS_GROUP_DELAY) begin
         d.lat_cnt = q.lat_cnt + 4'h1;
      end
      if (d.lat_cnt == `DMPS_GROUP_DELAY) begin
         d.ready = 1'b1;
      end
      d.pump = (d.st != DMPS_OFF);
      d.path = (d.st == DMPS_ENABLED) || (d.st == DMPS_MUTING);
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else if (clk_en_i) begin
         q <= d;
      end
   end

   assign state_o          = q.st;
   assign charge_pump_on_o = q.pump;
   assign out_path_on_o    = q.path;
   assign gain_o           = q.gain;
   assign ratio_o          = q.ratio;
   assign ratio_lock_o     = q.lock;
   assign narrow_mode_o    = q.narrow;
   assign pass_edge_o      = q.pass_edge;
   assign stop_edge_o      = q.stop_edge;
   assign filter_ready_o   = q.ready;
endmodule // dmps_device

//--- dmps_assertions.sv
`timescale 1ns/1ps
module dmps_assertions
   import dmps_pkg::*;
#(
   parameter int RAMP_LEN = 8
) (
   input wire logic              core_clk_i,
   input wire logic              reset_n_i,
   input wire logic              mclk,
   input wire logic              mute_n,
   input wire dmps_pkg::dmps_pwr_t  state_o,
   input wire logic              charge_pump_on_o,
   input wire logic              out_path_on_o,
   input wire dmps_pkg::dmps_gain_t gain_o,
   input wire logic              narrow_mode_o,
   input wire dmps_pkg::dmps_edge_t pass_edge_o,
   input wire dmps_pkg::dmps_edge_t stop_edge_o,
   input wire logic              filter_ready_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Cycles since the last master clock edge, saturating
   logic [7:0] idle_q, idle_d;
   logic       mclk_q;
   always_comb idle_d = (mclk != mclk_q) ? 8'h00 : idle_q + {7'h0, idle_q != 8'hff};
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idle_q <= 8'h00;
         mclk_q <= 1'b0;
      end else begin
         idle_q <= idle_d;
         mclk_q <= mclk;
      end
   end
   a_mclk_loss_off: assert property (idle_q > 8'h6e |-> state_o == DMPS_OFF)
      else $error("state not off after master clock loss");
   a_pump_off_idle: assert property (
      $stable(state_o) && state_o == DMPS_OFF |-> !charge_pump_on_o && !out_path_on_o)
      else $error("power on while off");
   a_standby_pump: assert property (
      $stable(state_o) && state_o == DMPS_STANDBY |-> charge_pump_on_o && !out_path_on_o)
      else $error("standby power outputs wrong");
   a_power_up_level: assert property (
      $past(state_o) == DMPS_OFF && state_o != DMPS_OFF |-> (state_o == DMPS_ENABLED) == mute_n)
      else $error("power up state does not follow mute level");
   a_mute_starts: assert property (
      $fell(mute_n) && state_o == DMPS_ENABLED |-> ##[1:6] state_o != DMPS_ENABLED)
      else $error("mute request ignored");
   a_ramp_step: assert property (
      state_o == DMPS_MUTING && $past(state_o) == DMPS_MUTING && gain_o != 10'h000
      && gain_o != $past(gain_o) |-> gain_o == $past(gain_o) - 10'h001)
      else $error("ramp step not one");
   a_ramp_ends: assert property (
      state_o == DMPS_MUTING && gain_o == 10'h000 |-> ##[1:2] state_o == DMPS_STANDBY)
      else $error("no standby after ramp");
   a_unmute_full: assert property (
      state_o == DMPS_ENABLED && $past(state_o) != DMPS_ENABLED |-> gain_o == RAMP_LEN)
      else $error("gain not full on enable");
   a_band_edges: assert property (
      filter_ready_o && $stable(narrow_mode_o) |-> pass_edge_o == (narrow_mode_o ? 10'h0f7
      : 10'h1c6) && stop_edge_o == (narrow_mode_o ? 10'h2f1 : 10'h222))
      else $error("band edges wrong");
   c_ramp_done: cover property (state_o == DMPS_MUTING ##1 state_o == DMPS_STANDBY);
   c_enabled: cover property (state_o == DMPS_ENABLED);
   c_clock_lost: cover property (idle_q > 8'h6e);
endmodule // dmps_assertions

//--- dac_mute_power_sequencer_tb.sv
`timescale 1ns/1ps
module dac_mute_power_sequencer_tb;
   import dmps_pkg::*;
   localparam int RL = 8;
   logic        clk, rst_n, hen, mrun, brun, mreq, rsel, pump, path, narrow, ready;
   logic        den, hold, mon, lock;
   dmps_pwr_t   state;
   dmps_gain_t  gain;
   dmps_ratio_t ratio;
   dmps_edge_t  pass_e, stop_e;
   int          bad_count, tests_run;
   dmps_if pins_if();
   dmps_host #(.MCLK_HALF(4)) dmps_host_i (.core_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(hen),
      .mclk_run_i(mrun), .bclk_run_i(brun), .mute_req_i(mreq), .ratio_sel_i(rsel),
      .pins(pins_if.host), .mclk_on_o(mon), .hold_o(hold));
   dmps_device #(.RAMP_LEN(RL)) dmps_device_i (.core_clk_i(clk), .reset_n_i(rst_n),
      .clk_en_i(den), .pins(pins_if.device), .state_o(state), .charge_pump_on_o(pump),
      .out_path_on_o(path), .gain_o(gain), .ratio_o(ratio), .ratio_lock_o(lock),
      .narrow_mode_o(narrow), .pass_edge_o(pass_e), .stop_edge_o(stop_e),
      .filter_ready_o(ready));
   dmps_assertions #(.RAMP_LEN(RL)) dmps_assertions_i (.core_clk_i(clk), .reset_n_i(rst_n),
      .mclk(pins_if.mclk), .mute_n(pins_if.mute_n), .state_o(state),
      .charge_pump_on_o(pump), .out_path_on_o(path), .gain_o(gain),
      .narrow_mode_o(narrow), .pass_edge_o(pass_e), .stop_edge_o(stop_e),
      .filter_ready_o(ready));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(logic [10:0] seen, logic [10:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wait_st(dmps_pwr_t s, int lim);
      for (int i = 0; i < lim && state !== s; i++) @(negedge clk);
      check(11'(state), 11'(s));
      if (state !== s) end_of_test();
   endtask
   task automatic wait_ready(int lim);
      for (int i = 0; i < lim && ready !== 1'b1; i++) @(negedge clk);
      check(11'(ready), 11'h001);
      if (ready !== 1'b1) end_of_test();
   endtask
   initial begin
      rst_n = 1'b0; hen = 1'b1; mrun = 1'b0; brun = 1'b0; mreq = 1'b1; rsel = 1'b1;
      bad_count = 0; tests_run = 0;
      den = 1'b1;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      check(11'(state), 11'(DMPS_OFF));
      mrun = 1'b1;
      brun = 1'b1;
      wait_st(DMPS_STANDBY, 3000);
      check(11'(mon), 11'h001);
      brun = 1'b0;
      // Longer than the bit clock timeout
      repeat (1500) @(negedge clk);
      check(11'(state), 11'(DMPS_STANDBY));
      $display("Test standby done");
      mreq = 1'b0;
      brun = 1'b1;
      wait_st(DMPS_ENABLED, 3000);
      check(11'(gain), 11'(RL));
      wait_ready(12 * 1024 + 200);
      check(ratio, 11'h080);
      check(11'(lock), 11'h001);
      check(11'(narrow), 11'h001);
      check(11'(pass_e), 11'h0f7);
      check(11'(stop_e), 11'h2f1);
      $display("Test narrow enable done");
      mreq = 1'b1;
      repeat (20) @(negedge clk);
      check(11'(state), 11'(DMPS_MUTING));
      repeat (3000) @(negedge clk);
      // Three frames minus a little: two or three ramp steps
      check(11'(gain inside {RL - 2, RL - 3}), 11'h001);
      mreq = 1'b0;
      wait_st(DMPS_ENABLED, 20);
      check(11'(gain), 11'(RL));
      mreq = 1'b1;
      wait_st(DMPS_STANDBY, 9000);
      check(11'(gain), 11'h000);
      check({9'h0, pump, path}, 11'h002);
      $display("Test soft mute done");
      mreq = 1'b0;
      wait_st(DMPS_ENABLED, 3000);
      brun = 1'b0;
      wait_st(DMPS_STANDBY, 1300);
      check(11'(gain), 11'h000);
      brun = 1'b1;
      wait_st(DMPS_ENABLED, 3000);
      // Freezing the host stops the master clock abruptly
      hen = 1'b0;
      wait_st(DMPS_OFF, 150);
      check(11'(pump), 11'h000);
      $display("Test clock loss done");
      rst_n = 1'b0;
      hen = 1'b1;
      den = 1'b0;
      rsel = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      // Frozen device must ignore the running clocks
      repeat (200) @(negedge clk);
      check(11'(state), 11'(DMPS_OFF));
      den = 1'b1;
      wait_st(DMPS_ENABLED, 3000);
      wait_ready(12 * 2048 + 500);
      check(ratio, 11'h100);
      check(11'(lock), 11'h001);
      check(11'(narrow), 11'h000);
      check(11'(pass_e), 11'h1c6);
      check(11'(stop_e), 11'h222);
      $display("Test wide enable done");
      // Ratio change while enabled: host holds mute for the settling span
      rsel = 1'b1;
      repeat (4) @(negedge clk);
      check(11'(hold), 11'h001);
      check(11'(pins_if.mute_n), 11'h000);
      wait_st(DMPS_STANDBY, 9000);
      // Quiet stop keeps the master clock running while muted
      mrun = 1'b0;
      repeat (4) @(negedge clk);
      check(11'(mon), 11'h001);
      check(11'(hold), 11'h001);
      $display("Test rate hold done");
      end_of_test();
   end
endmodule // dac_mute_power_sequencer_tb
